// [rtl/rps_pkg.sv]
// rps_pkg: shared constants and types for the repeater reset and port swap block
// assumes a single 100 MHz clock; no software-visible registers
package rps_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_DELAY_MS = 1;
  localparam int READY_DELAY_MS = 3;
  localparam int MIN_RESET_PULSE_US = 10;
  localparam int STRAP_DELAY_CYC = STRAP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int READY_DELAY_CYC = READY_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MIN_RESET_PULSE_CYC = MIN_RESET_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int INT_RESET_CYC = 16;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_SWAP = 1'b0;
  localparam logic [1:0] RST_ROLE = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PWRDN = 3'h0,
    ST_SUPPLY = 3'h1,
    ST_INTRST = 3'h2,
    ST_STRAP = 3'h3,
    ST_READY_WAIT = 3'h4,
    ST_ACTIVE = 3'h5
  } rps_state_t;

  // one usb port's line state and drive, carried as a unit
  typedef struct packed {
    logic [1:0] line;
    logic oe;
  } rps_port_t;

  // role enables received from the soc for one repeater
  typedef struct packed {
    logic host_en;
    logic periph_en;
  } rps_role_req_t;

endpackage : rps_pkg

// [rtl/rps_sync2.sv]
// rps_sync2: two flip-flop synchroniser for asynchronous level inputs
// assumes inputs may change at any time relative to clk
`timescale 1ns/100ps
module rps_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : rps_sync2

// [rtl/rps_top.sv]
// rps_top: reset sequencing, strap latch and 2:2 crossbar of a dual repeater
// assumes reset_n_pin, strap, supplies and role enables are asynchronous pins
//
// Contract
// - after pin release, wait internal reset then 1 ms, then latch swap strap.
// - strap changes while pin high are ignored; orientation holds latched value.
// - strap 0 maps port0 to A, port1 to B; strap 1 swaps both.
// - host-side interface ready within 3 ms of later of release or supplies good.
// - after readiness delay each repeater leaves reset and accepts packets.
// - outside holds pin low 10 us; such a pulse fully resets device.
// - while pin low, device sits in power-down with repeaters inactive; code powers down only once pin has been low MIN_PULSE cycles.
// - each repeater configured host or device role independently.
// - each connector port supports low, full and high speed.
// - after reset each repeater picks role from host or peripheral enable.
// - pin released before supplies stable keeps internal reset until stable.
`timescale 1ns/100ps
module rps_top
  import rps_pkg::*;
#(
  parameter int STRAP_DELAY = rps_pkg::STRAP_DELAY_CYC,
  parameter int READY_DELAY = rps_pkg::READY_DELAY_CYC,
  parameter int MIN_PULSE = rps_pkg::MIN_RESET_PULSE_CYC,
  parameter int INT_RESET = rps_pkg::INT_RESET_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset pin, strap and supply monitors
  input wire logic reset_n_pin,
  input wire logic swap_strap,
  input wire logic supplies_good,
  // role enables from the soc, one per repeater
  input wire rps_pkg::rps_role_req_t role_req_0,
  input wire rps_pkg::rps_role_req_t role_req_1,
  // host-side ports (as repeated by the datapath)
  input wire rps_pkg::rps_port_t host_side_port_0,
  input wire rps_pkg::rps_port_t host_side_port_1,
  // connector-side ports
  output rps_pkg::rps_port_t connector_port_a,
  output rps_pkg::rps_port_t connector_port_b,
  // status
  output logic power_down,
  output logic iface_ready,
  output logic swap_latched,
  output logic [1:0] host_role,
  output logic [1:0] device_role
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  localparam int CW = 32;
  if (STRAP_DELAY < 1 || READY_DELAY < STRAP_DELAY + INT_RESET + 6 || MIN_PULSE < 1
      || INT_RESET < 1) begin : g_bad_param
    $error("rps_top: delay parameters out of range");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pin_raw;
  logic [6:0] pin_sync;
  assign pin_raw = {reset_n_pin, swap_strap, supplies_good, role_req_0, role_req_1};
  rps_sync2 #(.WIDTH(7)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_raw),
    .q(pin_sync)
  );
  logic rstn_s;
  logic strap_s;
  logic sup_s;
  rps_role_req_t req0_s;
  rps_role_req_t req1_s;
  assign rstn_s = pin_sync[6];
  assign strap_s = pin_sync[5];
  assign sup_s = pin_sync[4];
  assign req0_s = pin_sync[3:2];
  assign req1_s = pin_sync[1:0];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  rps_state_t state_ff;
  rps_state_t nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] low_ff;
  logic [CW-1:0] nxt_low;
  logic full_reset;
  logic swap_ff;
  logic nxt_swap;
  logic [1:0] host_ff;
  logic [1:0] nxt_host;
  logic [1:0] dev_ff;
  logic [1:0] nxt_dev;

  // low-time counter: a pulse of at least MIN_PULSE cycles is a full reset
  assign full_reset = (low_ff >= CW'(MIN_PULSE));
  assign nxt_low = rstn_s ? '0 : (full_reset ? low_ff : low_ff + 1'b1);

  // next state; readiness counted from the later of release and supplies good
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    case (state_ff)
      ST_PWRDN: begin
        nxt_cnt = '0;
        if (rstn_s) begin
          nxt_state = ST_SUPPLY;
        end
      end
      ST_SUPPLY: begin
        nxt_cnt = '0;
        if (sup_s) begin
          nxt_state = ST_INTRST;
        end
      end
      ST_INTRST: begin
        if (cnt_ff >= CW'(INT_RESET - 1)) begin
          nxt_state = ST_STRAP;
        end
      end
      ST_STRAP: begin
        if (cnt_ff >= CW'(INT_RESET + STRAP_DELAY - 1)) begin
          nxt_state = ST_READY_WAIT;
        end
      end
      ST_READY_WAIT: begin
        // sync and entry latency (up to six cycles) come off the budget,
        // so ready never lands later than READY_DELAY after the later of release and supplies good
        if (cnt_ff >= CW'(READY_DELAY - 6)) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        nxt_cnt = cnt_ff;
      end
      default: begin
        nxt_state = ST_PWRDN;
        nxt_cnt = '0;
      end
    endcase
    if (!sup_s || full_reset) begin
      nxt_state = ST_PWRDN;
      nxt_cnt = '0;
    end
  end

  // strap latched once; cleared by a full reset, ignored otherwise
  assign nxt_swap = (state_ff == ST_PWRDN) ? RST_SWAP :
                    ((state_ff == ST_STRAP) && (nxt_state == ST_READY_WAIT)) ? strap_s :
                    swap_ff;

  // each repeater picks its role independently once active
  assign nxt_host = (nxt_state == ST_ACTIVE) ?
                    {req1_s.host_en, req0_s.host_en} : RST_ROLE;
  assign nxt_dev = (nxt_state == ST_ACTIVE) ?
                   {req1_s.periph_en & ~req1_s.host_en,
                    req0_s.periph_en & ~req0_s.host_en} : RST_ROLE;

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_PWRDN;
      cnt_ff <= '0;
      low_ff <= '0;
      swap_ff <= RST_SWAP;
      host_ff <= RST_ROLE;
      dev_ff <= RST_ROLE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
      swap_ff <= nxt_swap;
      host_ff <= nxt_host;
      dev_ff <= nxt_dev;
    end
  end

  // ---------------------------------------------------------------
  // crossbar and outputs
  // ---------------------------------------------------------------
  rps_port_t nxt_port_a;
  rps_port_t nxt_port_b;
  logic active;
  // ls/fs/hs line states pass unchanged, so every speed goes through
  assign active = (nxt_state == ST_ACTIVE);
  assign nxt_port_a = !active ? '0 : (nxt_swap ? host_side_port_1 : host_side_port_0);
  assign nxt_port_b = !active ? '0 : (nxt_swap ? host_side_port_0 : host_side_port_1);

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      connector_port_a <= '0;
      connector_port_b <= '0;
      power_down <= 1'b1;
      iface_ready <= 1'b0;
      swap_latched <= RST_SWAP;
      host_role <= RST_ROLE;
      device_role <= RST_ROLE;
    end else begin
      connector_port_a <= nxt_port_a;
      connector_port_b <= nxt_port_b;
      power_down <= (nxt_state == ST_PWRDN);
      iface_ready <= active;
      swap_latched <= nxt_swap;
      host_role <= nxt_host;
      device_role <= nxt_dev;
    end
  end

endmodule : rps_top

// [sim/rps_monitor.sv]
// rps_monitor: port checks of rps_top
// assumes sim counts (MIN_PULSE 5) and 2-flop input sync
`timescale 1ns/100ps
module rps_monitor
  import rps_pkg::*;
#(
  parameter int READY_DELAY = 60
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire logic reset_n_pin,
  input wire logic supplies_good,
  input wire rps_pkg::rps_role_req_t role_req_0,
  input wire rps_pkg::rps_role_req_t role_req_1,
  input wire rps_pkg::rps_port_t host_side_port_0,
  input wire rps_pkg::rps_port_t host_side_port_1,
  // outputs
  input wire rps_pkg::rps_port_t connector_port_a,
  input wire rps_pkg::rps_port_t connector_port_b,
  input wire logic power_down,
  input wire logic iface_ready,
  input wire logic swap_latched,
  input wire logic [1:0] host_role,
  input wire logic [1:0] device_role
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int cnt_ff;
  // cycles spent waiting for readiness with pin and supplies up
  always_ff @(posedge clk) begin
    if (rst || !reset_n_pin || !supplies_good || iface_ready) cnt_ff <= 0;
    else cnt_ff <= cnt_ff + 1;
  end
  // ----------------
  // properties
  // ----------------
  sequence s_live; iface_ready && $past(iface_ready); endsequence
  sequence s_pin_low; (!reset_n_pin)[*8]; endsequence
  sequence s_roles_steady;
    (iface_ready && $stable(role_req_0) && $stable(role_req_1))[*4];
  endsequence
  property p_straight; s_live ##0 !swap_latched |-> connector_port_a == $past(host_side_port_0)
    && connector_port_b == $past(host_side_port_1); endproperty
  property p_swap; s_live ##0 swap_latched |-> connector_port_a == $past(host_side_port_1)
    && connector_port_b == $past(host_side_port_0); endproperty
  property p_idle; !iface_ready && !$past(iface_ready) |-> connector_port_a == 3'h0
    && connector_port_b == 3'h0; endproperty
  property p_swap_hold; iface_ready |-> $stable(swap_latched); endproperty
  property p_roles; s_roles_steady |-> host_role == {role_req_1.host_en, role_req_0.host_en}
    && device_role == {role_req_1.periph_en & !role_req_1.host_en,
    role_req_0.periph_en & !role_req_0.host_en}; endproperty
  property p_pd; s_pin_low |-> ##[0:4] power_down && !iface_ready; endproperty
  property p_ready_late; cnt_ff <= READY_DELAY; endproperty
  property p_ready_early; $rose(iface_ready) |-> cnt_ff >= READY_DELAY - 1; endproperty
  a_straight: assert property (p_straight) else $error("xbar straight");
  a_swap: assert property (p_swap) else $error("xbar swapped");
  a_idle: assert property (p_idle) else $error("ports not idle");
  a_swap_hold: assert property (p_swap_hold) else $error("swap moved");
  a_roles: assert property (p_roles) else $error("role select");
  a_pd: assert property (p_pd) else $error("no power down");
  a_ready_late: assert property (p_ready_late) else $error("ready late");
  a_ready_early: assert property (p_ready_early) else $error("ready early");
endmodule : rps_monitor
bind rps_top rps_monitor #(.READY_DELAY(READY_DELAY)) rps_monitor_inst (.clk, .rst,
  .reset_n_pin, .supplies_good, .role_req_0, .role_req_1, .host_side_port_0,
  .host_side_port_1, .connector_port_a, .connector_port_b, .power_down, .iface_ready,
  .swap_latched, .host_role, .device_role);

// [sim/rps_soc_model.sv]
// rps_soc_model: soc and system pins in front of the repeater
// assumes bench calls its tasks at falling edges
`timescale 1ns/100ps
module rps_soc_model
  import rps_pkg::*;
(
  // clock
  input wire logic clk,
  // pins toward the repeater
  output logic reset_n_pin,
  output logic swap_strap,
  output logic supplies_good,
  output rps_pkg::rps_role_req_t role_req_0,
  output rps_pkg::rps_role_req_t role_req_1,
  output rps_pkg::rps_port_t host_side_port_0,
  output rps_pkg::rps_port_t host_side_port_1
);
  int seed = 26845;
  // start in reset with supplies up
  initial begin
    {reset_n_pin, swap_strap, supplies_good} = 3'h1;
    {role_req_0, role_req_1, host_side_port_0, host_side_port_1} = 10'h000;
  end
  // traffic redrawn at random every cycle so a stale value matches only by chance
  always @(negedge clk) begin
    host_side_port_0 <= rps_port_t'(3'($random(seed)));
    host_side_port_1 <= rps_port_t'(3'($random(seed)));
  end
  // pin low for low_cyc cycles; strap set up at release, held after
  task automatic pulse(input int low_cyc, input logic strap);
    reset_n_pin = 1'b0;
    repeat (low_cyc) @(negedge clk);
    swap_strap = strap;
    reset_n_pin = 1'b1;
  endtask : pulse
  // strap and role enables
  task automatic pins(input logic [4:0] v);
    {swap_strap, role_req_1, role_req_0} = v;
  endtask : pins
  // random role enables for both repeaters, strap untouched
  task automatic roles_rand();
    {role_req_1, role_req_0} = 4'($random(seed));
  endtask : roles_rand
  task automatic supply(input logic v);
    supplies_good = v;
  endtask : supply
endmodule : rps_soc_model

// [sim/rps_top_tb_top.sv]
// rps_top_tb_top: boot, swap, glitch, role and late-supply runs
// assumes shortened counts; pins driven by the soc model
`timescale 1ns/100ps
module rps_top_tb_top;
  import rps_pkg::*;
  localparam int RD = 60;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n_pin, swap_strap, supplies_good, power_down, iface_ready, swap_latched;
  rps_role_req_t role_req_0, role_req_1;
  rps_port_t host_side_port_0, host_side_port_1, connector_port_a, connector_port_b;
  logic [1:0] host_role, device_role;
  int mismatches = 0;
  int checks = 0;
  int exp_swap = 0;
  bit live = 1'b0;
  logic [5:0] hq[$];
  always #5 clk = ~clk;
  rps_soc_model rps_soc_model_inst (.clk, .reset_n_pin, .swap_strap, .supplies_good,
    .role_req_0, .role_req_1, .host_side_port_0, .host_side_port_1);
  rps_top #(.STRAP_DELAY(20), .READY_DELAY(RD), .MIN_PULSE(5), .INT_RESET(4)) rps_top_inst (
    .clk, .rst, .reset_n_pin, .swap_strap, .supplies_good, .role_req_0, .role_req_1,
    .host_side_port_0, .host_side_port_1, .connector_port_a, .connector_port_b,
    .power_down, .iface_ready, .swap_latched, .host_role, .device_role);
  task automatic chk(input string n, input logic [5:0] e, input logic [5:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // reference crossbar: outputs follow inputs taken at the same edge
  always @(posedge clk) hq.push_back({host_side_port_1, host_side_port_0});
  always @(negedge clk) begin
    if (live) chk("xbar", exp_swap ? {hq[$][2:0], hq[$][5:3]} : hq[$],
      {connector_port_b, connector_port_a});
  end
  // full reset, optionally with supplies late, then bounded wait for ready
  task automatic boot(input logic strap, input logic late);
    int n;
    live = 1'b0;
    if (late) rps_soc_model_inst.supply(1'b0);
    rps_soc_model_inst.pulse(20, strap);
    chk("pd", 6'h1, 6'(power_down));
    chk("off", 6'h0, {connector_port_b, connector_port_a});
    exp_swap = strap;
    if (late) begin
      repeat (RD + 20) @(negedge clk);
      chk("held", 6'h0, 6'(iface_ready));
      rps_soc_model_inst.supply(1'b1);
    end
    n = 0;
    while (iface_ready !== 1'b1 && n < RD + 40) begin
      @(negedge clk);
      n++;
    end
    chk("ready", 6'h1, 6'(n >= RD - 1 && n <= RD));
    if (iface_ready !== 1'b1) results();
    chk("swap", 6'(strap), 6'(swap_latched));
    @(negedge clk);
    live = 1'b1;
    repeat (20) @(negedge clk);
  endtask : boot
  initial begin
    logic [1:0] r0, r1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    boot(1'b0, 1'b0);
    rps_soc_model_inst.pins(5'h10);
    repeat (10) @(negedge clk);
    chk("keep", 6'h0, 6'(swap_latched));
    rps_soc_model_inst.pulse(2, 1'b1);
    repeat (10) @(negedge clk);
    chk("glitch", 6'h1, 6'(iface_ready));
    boot(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      if (i < 4) rps_soc_model_inst.pins({1'b1, 2'(3 - i), 2'(i)});
      else rps_soc_model_inst.roles_rand();
      repeat (8) @(negedge clk);
      r0 = role_req_0;
      r1 = role_req_1;
      chk("roles", {2'h0, r1[1], r0[1], r1[0] & ~r1[1], r0[0] & ~r0[1]},
        {2'h0, host_role, device_role});
    end
    boot(1'b0, 1'b1);
    results();
  end
endmodule : rps_top_tb_top
